// ==== logic/isr_pkg.sv ====
// Operation
// - Config bits 4:3 select oscillation amplitude.
// - Config bits 2:0 select response time.
// - Comparator bit sets below low, clears above high.
// - Wake-up bit low when triggered, high disabled.
// - Oscillator fail bit high when oscillator stopped.
// - Data-ready bit low when new result waits.
// - Interrupt pin mode selects wake, compare, ready.
// - Power bit 0 high selects active; resets standby.
// - Frequency count read at 0x23, 0x24, 0x25.
// - Results latch only when proximity read starts.
// - High threshold resets 0xFF, low 0x00.
// - Registers 0x01 to 0x04 read-only while active.
package isr_pkg;

    // =========================================================
    // Register offsets
    localparam logic [7:0] ISR_OFS_REVISION  = 8'h00;
    localparam logic [7:0] ISR_OFS_RES_MAX   = 8'h01;
    localparam logic [7:0] ISR_OFS_RES_MIN   = 8'h02;
    localparam logic [7:0] ISR_OFS_MIN_FREQ  = 8'h03;
    localparam logic [7:0] ISR_OFS_CONV_CFG  = 8'h04;
    localparam logic [7:0] ISR_OFS_FIXED_05  = 8'h05;
    localparam logic [7:0] ISR_OFS_THR_HIGH  = 8'h07;
    localparam logic [7:0] ISR_OFS_THR_LOW   = 8'h09;
    localparam logic [7:0] ISR_OFS_IRQ_CFG   = 8'h0A;
    localparam logic [7:0] ISR_OFS_PWR_CFG   = 8'h0B;
    localparam logic [7:0] ISR_OFS_STATUS    = 8'h20;
    localparam logic [7:0] ISR_OFS_PROX      = 8'h22;
    localparam logic [7:0] ISR_OFS_FCNT_LOW  = 8'h23;
    localparam logic [7:0] ISR_OFS_FCNT_MID  = 8'h24;
    localparam logic [7:0] ISR_OFS_FCNT_HIGH = 8'h25;

    // =========================================================
    // Reset values
    localparam logic [7:0] ISR_RST_MIN_FREQ  = 8'h45;
    localparam logic [7:0] ISR_RST_CONV_CFG  = 8'h1B;
    localparam logic [7:0] ISR_RST_THR_HIGH  = 8'hFF;
    localparam logic [7:0] ISR_RST_THR_LOW   = 8'h00;
    localparam logic [7:0] ISR_RST_IRQ_CFG   = 8'h00;
    localparam logic [7:0] ISR_RST_PWR_CFG   = 8'h00;
    localparam logic [7:0] ISR_RST_FIXED_05  = 8'h01;
    localparam logic [7:0] ISR_RST_RES_MAX   = 8'h0E;
    localparam logic [7:0] ISR_RST_RES_MIN   = 8'h14;

    // =========================================================
    // Field positions
    localparam int ISR_POS_AMP_LO   = 3;
    localparam int ISR_POS_OSC_FAIL = 7;
    localparam int ISR_POS_READY_N  = 6;
    localparam int ISR_POS_WAKE     = 5;
    localparam int ISR_POS_CMP      = 4;
    localparam int ISR_POS_PWR      = 0;

    // Field masks for writable bits; reserved bits stay zero.
    localparam logic [7:0] ISR_MSK_CONV_CFG = 8'h1F;
    localparam logic [7:0] ISR_MSK_IRQ_CFG  = 8'h07;
    localparam logic [7:0] ISR_MSK_PWR_CFG  = 8'h01;

    // =========================================================
    // Encodings
    localparam logic [1:0] ISR_AMP_1V   = 2'h0;
    localparam logic [1:0] ISR_AMP_2V   = 2'h1;
    localparam logic [1:0] ISR_AMP_4V   = 2'h2;
    localparam logic [2:0] ISR_IRQ_OFF  = 3'h0;
    localparam logic [2:0] ISR_IRQ_WAKE = 3'h1;
    localparam logic [2:0] ISR_IRQ_CMP  = 3'h2;
    localparam logic [2:0] ISR_IRQ_RDY  = 3'h4;

    // Response time in sensor periods per code; 0 for reserved codes.
    localparam logic [12:0] ISR_RESP_192  = 13'h00C0;
    localparam logic [12:0] ISR_RESP_6144 = 13'h1800;

    // Identity byte: value is arbitrary.
    localparam logic [7:0] ISR_REVISION_ID = 8'h5A;

    // =========================================================
    // Carriers
    typedef struct packed {
        logic        valid;
        logic [7:0]  prox;
        logic [23:0] freq_count;
    } isr_result_type;

    typedef struct packed {
        logic       en;
        logic       wr;
        logic [7:0] addr;
        logic [7:0] wdata;
    } isr_access_type;

endpackage

// ==== logic/isr_register_bank.sv ====
// =============================================================
// Register bank of the inductive sensor converter. Accesses come
// from the serial port front end as one-cycle strobes; read data
// is registered and valid the cycle after the strobe.
module isr_register_bank
    import isr_pkg::*;
(
    input  wire logic           CLK,
    input  wire logic           SYS_RST,
    input  wire isr_access_type ACCESS,
    output logic [7:0]          RDATA,
    output logic                RVALID,
    input  wire isr_result_type CONV_RESULT,
    input  wire logic           OSC_FAIL,
    output logic [7:0]          RES_MAX,
    output logic [7:0]          RES_MIN,
    output logic [7:0]          MIN_SENSOR_FREQ,
    output logic [1:0]          AMPLITUDE,
    output logic [12:0]         RESPONSE_TIME,
    output logic                CONVERT_EN,
    output logic                IRQ_PIN_N
);

    // =========================================================
    // Decoding
    function automatic logic hit(input logic [7:0] a,
                                 input logic [7:0] ofs);
        hit = (a == ofs);
    endfunction

    function automatic logic [12:0] resp_periods(input logic [2:0] c);
        resp_periods = (c < 3'h2) ? 13'h0000
                     : 13'(ISR_RESP_192 << (c - 3'h2));
    endfunction

    logic [7:0]  res_max_q;
    logic [7:0]  res_min_q;
    logic [7:0]  min_freq_q;
    logic [7:0]  conv_cfg_q;
    logic [7:0]  thr_high_q;
    logic [7:0]  thr_low_q;
    logic [7:0]  irq_cfg_q;
    logic [7:0]  pwr_cfg_q;
    logic        cmp_q;
    logic        wake_q;
    logic [7:0]  rdata_q;
    logic        rvalid_q;
    logic [7:0]  rdata_d;
    logic [7:0]  prox_view;
    logic [23:0] fcnt_view;
    logic        fresh;

    wire logic active     = pwr_cfg_q[ISR_POS_PWR];
    wire logic wr         = ACCESS.en & ACCESS.wr;
    wire logic rd         = ACCESS.en & ~ACCESS.wr;
    wire logic cfg_locked = active;
    wire logic wr_cfg     = wr & ~cfg_locked;
    wire logic take       = rd & hit(ACCESS.addr, ISR_OFS_PROX);
    wire logic [2:0] irq_mode = irq_cfg_q[2:0];
    wire logic [7:0] wdata    = ACCESS.wdata;

    // =========================================================
    // Result snapshot
    isr_result_latch u_latch (
        .clk      (CLK),
        .rst      (SYS_RST),
        .conv     (CONV_RESULT),
        .take     (take),
        .prox_q   (prox_view),
        .freq_count_q (fcnt_view),
        .fresh_q  (fresh)
    );

    // =========================================================
    // Writable registers
    always_ff @(posedge CLK or posedge SYS_RST) begin
        if (SYS_RST) begin
            res_max_q  <= ISR_RST_RES_MAX;
            res_min_q  <= ISR_RST_RES_MIN;
            min_freq_q <= ISR_RST_MIN_FREQ;
            conv_cfg_q <= ISR_RST_CONV_CFG;
        end else if (wr_cfg) begin
            if (hit(ACCESS.addr, ISR_OFS_RES_MAX))
                res_max_q <= wdata;
            if (hit(ACCESS.addr, ISR_OFS_RES_MIN))
                res_min_q <= wdata;
            if (hit(ACCESS.addr, ISR_OFS_MIN_FREQ))
                min_freq_q <= wdata;
            if (hit(ACCESS.addr, ISR_OFS_CONV_CFG))
                conv_cfg_q <= wdata & ISR_MSK_CONV_CFG;
        end
    end

    always_ff @(posedge CLK or posedge SYS_RST) begin
        if (SYS_RST) begin
            thr_high_q <= ISR_RST_THR_HIGH;
            thr_low_q  <= ISR_RST_THR_LOW;
            irq_cfg_q  <= ISR_RST_IRQ_CFG;
            pwr_cfg_q  <= ISR_RST_PWR_CFG;
        end else if (wr) begin
            if (hit(ACCESS.addr, ISR_OFS_THR_HIGH))
                thr_high_q <= wdata;
            if (hit(ACCESS.addr, ISR_OFS_THR_LOW))
                thr_low_q <= wdata;
            if (hit(ACCESS.addr, ISR_OFS_IRQ_CFG))
                irq_cfg_q <= wdata & ISR_MSK_IRQ_CFG;
            if (hit(ACCESS.addr, ISR_OFS_PWR_CFG))
                pwr_cfg_q <= wdata & ISR_MSK_PWR_CFG;
        end
    end

    // =========================================================
    // Comparator and wake-up
    // Thresholds are compared against the latched proximity view, so
    // the status byte agrees with the value the next proximity read returns.
    wire logic below_low  = prox_view < thr_low_q;
    wire logic above_high = prox_view > thr_high_q;
    wire logic wake_on    = active && (irq_mode == ISR_IRQ_WAKE);

    always_ff @(posedge CLK or posedge SYS_RST) begin
        if (SYS_RST) begin
            cmp_q  <= 1'b0;
            wake_q <= 1'b1;
        end else begin
            if (below_low)
                cmp_q <= 1'b1;
            else if (above_high)
                cmp_q <= 1'b0;
            // Between thresholds cmp_q keeps its value.
            if (!wake_on)
                wake_q <= 1'b1;
            else if (above_high)
                wake_q <= 1'b0;
        end
    end

    // =========================================================
    // Read mux
    wire logic [7:0] status_byte = {OSC_FAIL,
                                    ~fresh,
                                    wake_q,
                                    cmp_q,
                                    4'h0};

    always_comb begin
        rdata_d = 8'h00;
        unique case (ACCESS.addr)
            ISR_OFS_REVISION:  rdata_d = ISR_REVISION_ID;
            ISR_OFS_RES_MAX:   rdata_d = res_max_q;
            ISR_OFS_RES_MIN:   rdata_d = res_min_q;
            ISR_OFS_MIN_FREQ:  rdata_d = min_freq_q;
            ISR_OFS_CONV_CFG:  rdata_d = conv_cfg_q;
            ISR_OFS_FIXED_05:  rdata_d = ISR_RST_FIXED_05;
            ISR_OFS_THR_HIGH:  rdata_d = thr_high_q;
            ISR_OFS_THR_LOW:   rdata_d = thr_low_q;
            ISR_OFS_IRQ_CFG:   rdata_d = irq_cfg_q;
            ISR_OFS_PWR_CFG:   rdata_d = pwr_cfg_q;
            ISR_OFS_STATUS:    rdata_d = status_byte;
            // The proximity read returns the view held before its own
            // take; the new result shows from the next read onward.
            ISR_OFS_PROX:      rdata_d = prox_view;
            ISR_OFS_FCNT_LOW:  rdata_d = fcnt_view[7:0];
            ISR_OFS_FCNT_MID:  rdata_d = fcnt_view[15:8];
            ISR_OFS_FCNT_HIGH: rdata_d = fcnt_view[23:16];
            default:           rdata_d = 8'h00;
        endcase
    end

    always_ff @(posedge CLK or posedge SYS_RST) begin
        if (SYS_RST) begin
            rdata_q  <= 8'h00;
            rvalid_q <= 1'b0;
        end else begin
            rvalid_q <= rd;
            if (rd)
                rdata_q <= rdata_d;
        end
    end

    // =========================================================
    // Outputs
    assign RDATA           = rdata_q;
    assign RVALID          = rvalid_q;
    assign RES_MAX         = res_max_q;
    assign RES_MIN         = res_min_q;
    assign MIN_SENSOR_FREQ = min_freq_q;
    assign AMPLITUDE       = conv_cfg_q[ISR_POS_AMP_LO +: 2];
    assign RESPONSE_TIME   = resp_periods(conv_cfg_q[2:0]);
    assign CONVERT_EN      = active;

    // Reserved pin modes leave the pin released high.
    assign IRQ_PIN_N = (irq_mode == ISR_IRQ_WAKE) ? wake_q
                     : (irq_mode == ISR_IRQ_CMP)  ? ~cmp_q
                     : (irq_mode == ISR_IRQ_RDY)  ? ~fresh
                     : 1'b1;

    // =========================================================
    // Checks
    sequence s_write_lock;
        active && wr && hit(ACCESS.addr, ISR_OFS_MIN_FREQ);
    endsequence

    sequence s_amp_lock;
        active && wr && hit(ACCESS.addr, ISR_OFS_CONV_CFG);
    endsequence

    sequence s_prox_read;
        rd && hit(ACCESS.addr, ISR_OFS_PROX);
    endsequence

    // The view takes what was pending at the take, not what lands
    // with it, so a conversion in that cycle waits for the next read.
    sequence s_view_copied;
        prox_view == $past(u_latch.pend_prox_q)
            && fcnt_view == $past(u_latch.pend_fcnt_q);
    endsequence

    a_cfg_write_lock : assert property (
        @(posedge CLK) disable iff (SYS_RST)
        s_write_lock |=> $stable(min_freq_q))
        else $error("Frequency setting changed while active.");

    a_amp_write_lock : assert property (
        @(posedge CLK) disable iff (SYS_RST)
        s_amp_lock |=> $stable(conv_cfg_q))
        else $error("Converter setting changed while active.");

    a_amp_field_map : assert property (
        @(posedge CLK) disable iff (SYS_RST)
        wr_cfg && hit(ACCESS.addr, ISR_OFS_CONV_CFG)
        |=> AMPLITUDE == $past(wdata[ISR_POS_AMP_LO +: 2]))
        else $error("Amplitude output off its field.");

    a_resp_code_low : assert property (
        @(posedge CLK) disable iff (SYS_RST)
        conv_cfg_q[2:0] == 3'h2 |-> RESPONSE_TIME == ISR_RESP_192)
        else $error("Response time code 2 misdecoded.");

    a_resp_code_map : assert property (
        @(posedge CLK) disable iff (SYS_RST)
        conv_cfg_q[2:0] == 3'h7 |-> RESPONSE_TIME == ISR_RESP_6144)
        else $error("Response time code 7 misdecoded.");

    a_cmp_below_low : assert property (
        @(posedge CLK) disable iff (SYS_RST)
        below_low |=> status_byte[ISR_POS_CMP])
        else $error("Comparator bit not set below low threshold.");

    a_cmp_above_high : assert property (
        @(posedge CLK) disable iff (SYS_RST)
        above_high && !below_low |=> !status_byte[ISR_POS_CMP])
        else $error("Comparator bit not cleared above high threshold.");

    a_cmp_hold_band : assert property (
        @(posedge CLK) disable iff (SYS_RST)
        !below_low && !above_high |=> $stable(cmp_q))
        else $error("Comparator moved inside the band.");

    a_wake_disabled : assert property (
        @(posedge CLK) disable iff (SYS_RST)
        !wake_on |=> status_byte[ISR_POS_WAKE])
        else $error("Wake bit low while wake-up disabled.");

    a_wake_trigger : assert property (
        @(posedge CLK) disable iff (SYS_RST)
        wake_on && above_high |=> !status_byte[ISR_POS_WAKE])
        else $error("Wake bit not low after wake-up trigger.");

    a_osc_fail_bit : assert property (
        @(posedge CLK) disable iff (SYS_RST)
        rd && hit(ACCESS.addr, ISR_OFS_STATUS)
        |=> RDATA[ISR_POS_OSC_FAIL] == $past(OSC_FAIL))
        else $error("Oscillator fail bit read wrong.");

    a_ready_after_conv : assert property (
        @(posedge CLK) disable iff (SYS_RST)
        CONV_RESULT.valid |=> !status_byte[ISR_POS_READY_N])
        else $error("Data ready not shown after conversion.");

    a_ready_cleared : assert property (
        @(posedge CLK) disable iff (SYS_RST)
        take && !CONV_RESULT.valid |=> status_byte[ISR_POS_READY_N])
        else $error("Data ready still shown after proximity read.");

    a_irq_wake_mode : assert property (
        @(posedge CLK) disable iff (SYS_RST)
        irq_mode == ISR_IRQ_WAKE |-> IRQ_PIN_N == status_byte[ISR_POS_WAKE])
        else $error("Interrupt pin not following wake bit.");

    a_irq_cmp_mode : assert property (
        @(posedge CLK) disable iff (SYS_RST)
        irq_mode == ISR_IRQ_CMP |-> IRQ_PIN_N == ~cmp_q)
        else $error("Interrupt pin not following comparator.");

    a_irq_rdy_mode : assert property (
        @(posedge CLK) disable iff (SYS_RST)
        irq_mode == ISR_IRQ_RDY |-> IRQ_PIN_N == ~fresh)
        else $error("Interrupt pin not following data ready.");

    a_irq_off_mode : assert property (
        @(posedge CLK) disable iff (SYS_RST)
        irq_mode == ISR_IRQ_OFF |-> IRQ_PIN_N == 1'b1)
        else $error("Interrupt pin asserted while disabled.");

    a_pwr_write : assert property (
        @(posedge CLK) disable iff (SYS_RST)
        wr && hit(ACCESS.addr, ISR_OFS_PWR_CFG)
        |=> CONVERT_EN == $past(wdata[ISR_POS_PWR]))
        else $error("Conversion enable not following power bit.");

    a_fcnt_low_read : assert property (
        @(posedge CLK) disable iff (SYS_RST)
        rd && hit(ACCESS.addr, ISR_OFS_FCNT_LOW)
        |=> RVALID && RDATA == fcnt_view[7:0])
        else $error("Count low byte read wrong.");

    a_fcnt_mid_read : assert property (
        @(posedge CLK) disable iff (SYS_RST)
        rd && hit(ACCESS.addr, ISR_OFS_FCNT_MID)
        |=> RVALID && RDATA == fcnt_view[15:8])
        else $error("Count middle byte read wrong.");

    a_fcnt_high_read : assert property (
        @(posedge CLK) disable iff (SYS_RST)
        rd && hit(ACCESS.addr, ISR_OFS_FCNT_HIGH)
        |=> RVALID && RDATA == fcnt_view[23:16])
        else $error("Count high byte read wrong.");

    a_prox_read_data : assert property (
        @(posedge CLK) disable iff (SYS_RST)
        s_prox_read |=> RVALID && RDATA == $past(prox_view))
        else $error("Proximity read returned the wrong snapshot.");

    a_take_copies : assert property (
        @(posedge CLK) disable iff (SYS_RST)
        s_prox_read |=> s_view_copied)
        else $error("Result view not copied on proximity read.");

    a_thr_reset_vals : assert property (
        @(posedge CLK)
        $fell(SYS_RST) |-> thr_high_q == 8'hFF && thr_low_q == 8'h00)
        else $error("Threshold reset values wrong.");

    a_thr_high_write : assert property (
        @(posedge CLK) disable iff (SYS_RST)
        wr && hit(ACCESS.addr, ISR_OFS_THR_HIGH) |=> thr_high_q == $past(wdata))
        else $error("High threshold write lost.");

    a_thr_low_write : assert property (
        @(posedge CLK) disable iff (SYS_RST)
        wr && hit(ACCESS.addr, ISR_OFS_THR_LOW) |=> thr_low_q == $past(wdata))
        else $error("Low threshold write lost.");
endmodule

// ==== logic/isr_result_latch.sv ====
// =============================================================
// Result snapshot: pending conversion is held until a read of
// the proximity register starts, then copied into the view.
module isr_result_latch
    import isr_pkg::*;
(
    input  wire logic           clk,
    input  wire logic           rst,
    input  wire isr_result_type conv,
    input  wire logic           take,
    output logic [7:0]          prox_q,
    output logic [23:0]         freq_count_q,
    output logic                fresh_q
);
    logic [7:0]  pend_prox_q;
    logic [23:0] pend_fcnt_q;

    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            pend_prox_q <= 8'h00;
            pend_fcnt_q <= 24'h000000;
        end else if (conv.valid) begin
            pend_prox_q <= conv.prox;
            pend_fcnt_q <= conv.freq_count;
        end
    end

    // A conversion landing with the take still counts as fresh.
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            prox_q   <= 8'h00;
            freq_count_q <= 24'h000000;
            fresh_q  <= 1'b0;
        end else begin
            if (take) begin
                prox_q   <= pend_prox_q;
                freq_count_q <= pend_fcnt_q;
            end
            fresh_q <= conv.valid | (fresh_q & ~take);
        end
    end

    a_latch_only_take : assert property (
        @(posedge clk) disable iff (rst)
        !$past(take) |-> $stable(prox_q) && $stable(freq_count_q))
        else $error("Result view changed without proximity read.");
endmodule

// ==== verif/inductive_sensor_register_bank_tb_top.sv ====
module inductive_sensor_register_bank_tb_top
    import isr_pkg::*;
();
    timeunit 1ns;
    timeprecision 100ps;

    logic           clk;
    logic           sys_rst;
    isr_access_type access;
    logic [7:0]     rdata;
    logic           rvalid;
    isr_result_type conv;
    logic           osc_fail;
    logic [7:0]     min_freq;
    logic [7:0]     res_max;
    logic [7:0]     res_min;
    logic [1:0]     amplitude;
    logic [12:0]    resp_time;
    logic           convert_en;
    logic           irq_pin_n;
    logic [7:0]     d;
    int             failures;
    int             checks_done;
    logic [12:0]    rt [8] = '{13'h0000, 13'h0000, 13'h00C0, 13'h0180,
                               13'h0300, 13'h0600, 13'h0C00, 13'h1800};

    isr_register_bank u_dut (
        .CLK(clk), .SYS_RST(sys_rst), .ACCESS(access), .RDATA(rdata),
        .RVALID(rvalid), .CONV_RESULT(conv), .OSC_FAIL(osc_fail),
        .RES_MAX(res_max), .RES_MIN(res_min), .MIN_SENSOR_FREQ(min_freq),
        .AMPLITUDE(amplitude), .RESPONSE_TIME(resp_time),
        .CONVERT_EN(convert_en), .IRQ_PIN_N(irq_pin_n)
    );

    isr_host_model u_host (
        .CLK(clk), .ACCESS(access), .RDATA(rdata), .RVALID(rvalid)
    );

    // =========================================================
    // Helpers
    task automatic chk(input string what, input logic [23:0] exp,
                       input logic [23:0] got);
        checks_done++;
        if (got !== exp) begin
            failures++;
            $display("unexpected %s: expected %h seen %h", what, exp, got);
        end
    endtask

    task automatic rchk(input logic [7:0] a, input logic [7:0] exp);
        u_host.rd(a, d);
        chk($sformatf("reg %h", a), {16'h0000, exp}, {16'h0000, d});
    endtask

    task automatic sbit(input int pos, input logic exp);
        u_host.rd(ISR_OFS_STATUS, d);
        chk($sformatf("status bit %0d", pos), {23'h0, exp}, {23'h0, d[pos]});
    endtask

    task automatic pin(input logic exp);
        chk("irq pin", {23'h0, exp}, {23'h0, irq_pin_n});
    endtask

    task automatic pulse(input logic [7:0] p, input logic [23:0] f);
        @(posedge clk);
        #1;
        conv = '{valid: 1'b1, prox: p, freq_count: f};
        @(posedge clk);
        #1;
        conv.valid = 1'b0;
    endtask

    task automatic latch(input logic [7:0] p);
        pulse(p, 24'h000000);
        u_host.rd(ISR_OFS_PROX, d);
        // Status and pin follow the new view one cycle after the take.
        @(posedge clk);
        #1;
    endtask

    task automatic wrap_up();
        $display("checks %0d mismatches %0d", checks_done, failures);
        if (failures == 0 && checks_done > 0) $display("== PASSED ==");
        else $display("== FAILED ==");
        $finish;
    endtask

    // =========================================================
    // Clock, watchdog and tests
    initial begin
        clk = 1'b0;
        forever #12.5 clk = ~clk;
    end

    initial begin
        repeat (20000) @(posedge clk);
        failures++;
        wrap_up();
    end

    initial begin
        sys_rst = 1'b1;
        conv = '0;
        osc_fail = 1'b0;
        failures = 0;
        checks_done = 0;
        repeat (3) @(posedge clk);
        #1 sys_rst = 1'b0;
        rchk(ISR_OFS_MIN_FREQ, 8'h45);
        rchk(ISR_OFS_REVISION, ISR_REVISION_ID);
        rchk(ISR_OFS_RES_MAX, 8'h0E);
        rchk(ISR_OFS_RES_MIN, 8'h14);
        rchk(ISR_OFS_FIXED_05, 8'h01);
        chk("res max", 24'h00000E, {16'h0000, res_max});
        chk("res min", 24'h000014, {16'h0000, res_min});
        rchk(ISR_OFS_CONV_CFG, 8'h1B);
        rchk(ISR_OFS_THR_HIGH, 8'hFF);
        rchk(ISR_OFS_THR_LOW, 8'h00);
        rchk(ISR_OFS_IRQ_CFG, 8'h00);
        rchk(ISR_OFS_PWR_CFG, 8'h00);
        rchk(8'h30, 8'h00);
        chk("convert enable", 24'h0, {23'h0, convert_en});
        pin(1'b1);
        $display("test reset values done");
        for (int i = 0; i < 8; i++) begin
            u_host.wr(ISR_OFS_CONV_CFG, {3'h0, 2'(i % 3), 3'(i)});
            chk("amplitude", 24'(i % 3), {22'h0, amplitude});
            chk("response", {11'h0, rt[i]}, {11'h0, resp_time});
        end
        u_host.wr(ISR_OFS_MIN_FREQ, 8'hB3);
        chk("min freq", 24'hB3, {16'h0, min_freq});
        $display("test configuration codes done");
        u_host.wr(ISR_OFS_THR_HIGH, 8'h80);
        u_host.wr(ISR_OFS_THR_LOW, 8'h20);
        pulse(8'h10, 24'h123456);
        sbit(ISR_POS_READY_N, 1'b0);
        u_host.rd(ISR_OFS_PROX, d);
        sbit(ISR_POS_READY_N, 1'b1);
        rchk(ISR_OFS_FCNT_LOW, 8'h56);
        rchk(ISR_OFS_FCNT_MID, 8'h34);
        rchk(ISR_OFS_FCNT_HIGH, 8'h12);
        rchk(ISR_OFS_PROX, 8'h10);
        pulse(8'h99, 24'hABCDEF);
        rchk(ISR_OFS_FCNT_LOW, 8'h56);
        rchk(ISR_OFS_PROX, 8'h10);
        rchk(ISR_OFS_FCNT_HIGH, 8'hAB);
        $display("test result snapshot done");
        sbit(ISR_POS_CMP, 1'b0);
        latch(8'h50);
        sbit(ISR_POS_CMP, 1'b0);
        latch(8'h10);
        sbit(ISR_POS_CMP, 1'b1);
        latch(8'h50);
        sbit(ISR_POS_CMP, 1'b1);
        $display("test comparator done");
        u_host.wr(ISR_OFS_IRQ_CFG, {5'h00, ISR_IRQ_CMP});
        pin(1'b0);
        latch(8'h90);
        pin(1'b1);
        u_host.wr(ISR_OFS_IRQ_CFG, {5'h00, ISR_IRQ_RDY});
        pin(1'b1);
        pulse(8'h90, 24'h000001);
        pin(1'b0);
        u_host.rd(ISR_OFS_PROX, d);
        pin(1'b1);
        u_host.wr(ISR_OFS_IRQ_CFG, {5'h00, ISR_IRQ_WAKE});
        u_host.wr(ISR_OFS_PWR_CFG, 8'h01);
        chk("convert enable", 24'h1, {23'h0, convert_en});
        u_host.wr(ISR_OFS_MIN_FREQ, 8'h11);
        rchk(ISR_OFS_MIN_FREQ, 8'hB3);
        latch(8'h10);
        latch(8'h90);
        sbit(ISR_POS_WAKE, 1'b0);
        pin(1'b0);
        u_host.wr(ISR_OFS_IRQ_CFG, {5'h00, ISR_IRQ_OFF});
        sbit(ISR_POS_WAKE, 1'b1);
        pin(1'b1);
        u_host.wr(ISR_OFS_PWR_CFG, 8'h00);
        u_host.wr(ISR_OFS_MIN_FREQ, 8'h11);
        rchk(ISR_OFS_MIN_FREQ, 8'h11);
        $display("test pin modes and power done");
        osc_fail = 1'b1;
        sbit(ISR_POS_OSC_FAIL, 1'b1);
        osc_fail = 1'b0;
        sbit(ISR_POS_OSC_FAIL, 1'b0);
        $display("test oscillator flag done");
        wrap_up();
    end
endmodule

// ==== verif/isr_host_model.sv ====
// =============================================================
// Host side of the register port: one-cycle strobes, read data
// taken in the cycle after the strobe.
module isr_host_model
    import isr_pkg::*;
(
    input  wire logic       CLK,
    output isr_access_type  ACCESS,
    input  wire logic [7:0] RDATA,
    input  wire logic       RVALID
);
    timeunit 1ns;
    timeprecision 100ps;

    initial ACCESS = '0;

    // Idle address and data are inverted so a stale value is never seen.
    task automatic release_bus();
        ACCESS.en = 1'b0;
        ACCESS.addr = ~ACCESS.addr;
        ACCESS.wdata = ~ACCESS.wdata;
    endtask

    // Callers pass full field values with reserved bits at zero.
    task automatic wr(input logic [7:0] a, input logic [7:0] v);
        @(posedge CLK);
        #1;
        ACCESS = '{en: 1'b1, wr: 1'b1, addr: a, wdata: v};
        @(posedge CLK);
        #1;
        release_bus();
    endtask

    // A missing valid pulse hands back unknown data so the compare fails.
    task automatic rd(input logic [7:0] a, output logic [7:0] v);
        @(posedge CLK);
        #1;
        ACCESS = '{en: 1'b1, wr: 1'b0, addr: a, wdata: 8'h00};
        @(posedge CLK);
        #1;
        v = (RVALID === 1'b1) ? RDATA : 8'hXX;
        release_bus();
    endtask
endmodule
